// *** src/gauge_consts.svh ***
// constants for the relax and learning control block
// assumes a 20 MHz pclk and one-second gauge ticks from the sampler
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_PACK_CFG      12'h000
`define OFF_LEARN_STAT    12'h004
`define OFF_CTRL          12'h008
`define OFF_QUIT_CUR      12'h00c
`define OFF_DSG_THR       12'h010
`define OFF_CHG_THR       12'h014
`define OFF_RELAX_TIMES   12'h018
`define OFF_QUIT_TIME     12'h01c
`define OFF_ENERGY_SCALE  12'h020
`define OFF_STATUS        12'h024
`define OFF_AVG_I_LAST    12'h028
`define OFF_AVG_P_LAST    12'h02c
`define OFF_DELTA_V       12'h030
`define OFF_QMAX          12'h034
`define OFF_RES_CHARGE    12'h038
`define OFF_RES_ENERGY    12'h03c
`define OFF_RES_TBL       12'h040

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PACK_RESERVE_COMP_SELECT_BIT   15
`define PACK_CFG_RESET    16'h0161
`define PACK_SUBCLASS     8'h40
`define PACK_SUB_OFFSET   8'h00
`define LS_LEARNED_OFF    8'h02
`define LS_EN_NONE        8'h04
`define LS_EN_QMAX        8'h05
`define LS_EN_ALL         8'h06
`define SCALE_UNIT        8'h01
`define SCALE_CENTI       8'h0a

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ            20000000
`define OCV_WAIT_S        360
`define SLOPE_LIMIT_UV    4
`endif

// *** src/gauge_pkg.sv ***
// types for the relax and learning control block
// assumes gauge_consts.svh supplies the numbers
package gauge_pkg;
   typedef enum logic [2:0] {
      ST_FLOW  = 3'b001,
      ST_RELAX = 3'b010,
      ST_OCV   = 3'b100
   } relax_state_t;
endpackage

// *** src/gauge_relax_ctrl.sv ***
// relax mode, learning status and last-run averages behind an apb slave
// assumes samples arrive on pclk with a one-cycle tick each second
//
// Summary of operation
// - enter relax when |avg current| < |quit current| for discharge relax time
// - also enter relax when |avg current| > |quit| for charge relax time
// - after six minutes relaxed, start open-circuit voltage readings
// - capacity update only when voltage slope below 4 uV/s
// - leave relax after current above quit current for quit relax time
// - learning status codes 02, 04, 05, 06 with their meanings
// - learning status changes only in learning or on enable command
// - scale 10 puts energy and power values in centi units; here only avg_p_last is scaled, energy values are not
// - hold reserve charge and energy after reports reach zero
// - reserve select bit picks loaded or no-load compensation
// - discharge flow only when magnitude exceeds discharge threshold
// - charge flow only when magnitude exceeds charge threshold
// - average current over each discharge, keep previous as last-run
// - multiply current by voltage, average per discharge, keep last-run
// - record largest voltage gap between load spikes and normal load
// - capacity starts from host value and device updates it
// - device updates resistance table, one entry per charge index
// - pack configuration word sits at subclass 64 offset 0
// - reserve select set means no-load compensation; default cleared
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "gauge_consts.svh"
module gauge_relax_ctrl
   import gauge_pkg::*;
#(
   parameter int RES_ENTRIES  = 15,
   parameter int OCV_WAIT_CYC = `OCV_WAIT_S
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic [31:0]             prdata,
   // measurement samples, pclk domain
   input  wire logic               sec_tick,
   input  wire logic signed [15:0] averaged_current,
   input  wire logic signed [15:0] inst_current,
   input  wire logic [15:0]        cell_voltage,
   input  wire logic [15:0]        voltage_slope_uv,
   input  wire logic [15:0]        spike_delta_v,
   input  wire logic [15:0]        remaining_charge,
   input  wire logic [15:0]        available_energy_report,
   input  wire logic [15:0]        no_load_reserve,
   input  wire logic [15:0]        loaded_reserve,
   input  wire logic               qmax_learn,
   input  wire logic [15:0]        qmax_new,
   input  wire logic               res_learn,
   input  wire logic [3:0]         res_index,
   input  wire logic [15:0]        res_value,
   // status out
   output logic                    relax_mode,
   output logic                    ocv_take,
   output logic                    qmax_update,
   output logic                    dsg_flow,
   output logic                    chg_flow,
   output logic                    reserve_active
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [15:0] pack_configuration_word;
   logic [7:0]  learning_status;
   logic [15:0] quit_current, dsg_thr, chg_thr;
   logic [15:0] dsg_relax_time, chg_relax_time, quit_relax_time;
   logic [7:0]  energy_scale;
   logic        algorithm_enable_cmd;
   logic [15:0] avg_i_last, avg_p_last, delta_v, qmax;
   logic [15:0] reserve_charge, reserve_energy;
   logic [15:0] res_tbl [RES_ENTRIES];
   relax_state_t state;
   logic [15:0] t_dsg, t_chg, t_quit;
   logic [15:0] t_ocv;
   logic [15:0] mag_avg, mag_inst, mag_quit;
   logic        wr, rd, dsg_now;
   logic [47:0] i_sum, p_sum;
   logic [15:0] n_samp;
   logic [31:0] pwr;

   assign mag_avg  = averaged_current[15] ? 16'(-averaged_current)
                                          : averaged_current;
   assign mag_inst = inst_current[15] ? 16'(-inst_current) : inst_current;
   assign mag_quit = quit_current;
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign dsg_now = inst_current[15] && (mag_inst > dsg_thr);
   assign pwr = 32'(mag_inst) * 32'(cell_voltage);

   // ----------------------------------------------------------------
   // apb slave: zero wait, unmapped reads zero and flags error
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel & ~penable) begin
            prdata <= 32'h0000_0000;
            if (paddr >= `OFF_RES_TBL &&
                paddr < 12'(`OFF_RES_TBL + 4 * RES_ENTRIES)) begin
               if (rd)
                  prdata <= {16'h0000, res_tbl[4'((paddr - `OFF_RES_TBL)
                                                  >> 2)]};
            end else begin
               case (paddr)
                  `OFF_PACK_CFG:     prdata <= {16'h0,
                                        pack_configuration_word};
                  `OFF_LEARN_STAT:   prdata <= {24'h0, learning_status};
                  `OFF_CTRL:         prdata <= {16'h0,
                     pack_configuration_word[`PACK_RESERVE_COMP_SELECT_BIT]
                     ? no_load_reserve : loaded_reserve};
                  `OFF_QUIT_CUR:     prdata <= {16'h0, quit_current};
                  `OFF_DSG_THR:      prdata <= {16'h0, dsg_thr};
                  `OFF_CHG_THR:      prdata <= {16'h0, chg_thr};
                  `OFF_RELAX_TIMES:  prdata <= {chg_relax_time,
                                                dsg_relax_time};
                  `OFF_QUIT_TIME:    prdata <= {16'h0, quit_relax_time};
                  `OFF_ENERGY_SCALE: prdata <= {24'h0, energy_scale};
                  `OFF_STATUS:       prdata <= {26'h0, reserve_active,
                                        chg_flow, dsg_flow, qmax_update,
                                        ocv_take, relax_mode};
                  `OFF_AVG_I_LAST:   prdata <= {16'h0, avg_i_last};
                  `OFF_AVG_P_LAST:   prdata <= {16'h0, avg_p_last};
                  `OFF_DELTA_V:      prdata <= {16'h0, delta_v};
                  `OFF_QMAX:         prdata <= {16'h0, qmax};
                  `OFF_RES_CHARGE:   prdata <= {16'h0, reserve_charge};
                  `OFF_RES_ENERGY:   prdata <= {16'h0, reserve_energy};
                  default:           pslverr <= 1'b1;
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // host-written configuration
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pack_configuration_word <= `PACK_CFG_RESET;
         quit_current    <= 16'h000a;
         dsg_thr         <= 16'h003c;
         chg_thr         <= 16'h004b;
         dsg_relax_time  <= 16'h003c;
         chg_relax_time  <= 16'h003c;
         quit_relax_time <= 16'h0001;
         energy_scale    <= `SCALE_UNIT;
         reserve_charge  <= 16'h0000;
         reserve_energy  <= 16'h0000;
         algorithm_enable_cmd <= 1'b0;
      end else begin
         algorithm_enable_cmd <= 1'b0;
         if (wr) begin
            case (paddr)
               `OFF_PACK_CFG:    pack_configuration_word <= pwdata[15:0];
               `OFF_CTRL:        algorithm_enable_cmd <= pwdata[0];
               `OFF_QUIT_CUR:    quit_current <= pwdata[15:0];
               `OFF_DSG_THR:     dsg_thr <= pwdata[15:0];
               `OFF_CHG_THR:     chg_thr <= pwdata[15:0];
               `OFF_RELAX_TIMES: begin
                  dsg_relax_time <= pwdata[15:0];
                  chg_relax_time <= pwdata[31:16];
               end
               `OFF_QUIT_TIME:   quit_relax_time <= pwdata[15:0];
               `OFF_ENERGY_SCALE: begin
                  // other values are ignored
                  if (pwdata[7:0] == `SCALE_UNIT ||
                      pwdata[7:0] == `SCALE_CENTI)
                     energy_scale <= pwdata[7:0];
               end
               `OFF_RES_CHARGE:  reserve_charge <= pwdata[15:0];
               `OFF_RES_ENERGY:  reserve_energy <= pwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // relax state machine and timers, counted in second ticks
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state  <= ST_FLOW;
         t_dsg  <= 16'h0000;
         t_chg  <= 16'h0000;
         t_quit <= 16'h0000;
         t_ocv  <= 16'h0000;
      end else if (sec_tick) begin
         // timers clear as soon as their condition drops
         t_dsg  <= (mag_avg < mag_quit) ? t_dsg + 16'h0001 : 16'h0000;
         t_chg  <= (mag_avg > mag_quit) ? t_chg + 16'h0001 : 16'h0000;
         t_quit <= (mag_avg > mag_quit) ? t_quit + 16'h0001 : 16'h0000;
         case (state)
            ST_FLOW: begin
               t_ocv <= 16'h0000;
               if ((mag_avg < mag_quit &&
                    t_dsg + 16'h0001 >= dsg_relax_time) ||
                   (mag_avg > mag_quit &&
                    t_chg + 16'h0001 >= chg_relax_time))
                  state <= ST_RELAX;
            end
            ST_RELAX, ST_OCV: begin
               if (state == ST_RELAX)
                  t_ocv <= t_ocv + 16'h0001;
               if (state == ST_RELAX &&
                   t_ocv + 16'h0001 >= 16'(OCV_WAIT_CYC))
                  state <= ST_OCV;
               if (mag_avg > mag_quit &&
                   t_quit + 16'h0001 >= quit_relax_time)
                  state <= ST_FLOW;
            end
            default: state <= ST_FLOW;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // flow classification and status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         relax_mode     <= 1'b0;
         ocv_take       <= 1'b0;
         qmax_update    <= 1'b0;
         dsg_flow       <= 1'b0;
         chg_flow       <= 1'b0;
         reserve_active <= 1'b0;
      end else begin
         relax_mode  <= (state != ST_FLOW);
         ocv_take    <= (state == ST_OCV);
         qmax_update <= (state == ST_OCV) &&
                        (voltage_slope_uv < 16'(`SLOPE_LIMIT_UV));
         dsg_flow    <= dsg_now;
         chg_flow    <= !inst_current[15] && (mag_inst > chg_thr);
         reserve_active <= (remaining_charge == 16'h0000) ||
                           (available_energy_report == 16'h0000);
      end
   end

   // ----------------------------------------------------------------
   // last-run averages over each discharge
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         i_sum      <= 48'h0;
         p_sum      <= 48'h0;
         n_samp     <= 16'h0000;
         avg_i_last <= 16'h0000;
         avg_p_last <= 16'h0000;
      end else if (sec_tick) begin
         if (dsg_now && n_samp != 16'hffff) begin
            i_sum  <= i_sum + 48'(mag_inst);
            p_sum  <= p_sum + 48'(pwr);
            n_samp <= n_samp + 16'h0001;
         end else if (!dsg_now && n_samp != 16'h0000) begin
            avg_i_last <= 16'(i_sum / 48'(n_samp));
            // energy scale 10 reports in centiwatts
            avg_p_last <= (energy_scale == `SCALE_CENTI)
                          ? 16'(p_sum / (48'(n_samp) * 48'd10000))
                          : 16'(p_sum / (48'(n_samp) * 48'd1000));
            i_sum  <= 48'h0;
            p_sum  <= 48'h0;
            n_samp <= 16'h0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // learned values: spike gap, capacity, resistance, status code
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delta_v         <= 16'h0000;
         qmax            <= 16'h03e8;
         learning_status <= `LS_LEARNED_OFF;
      end else begin
         if (spike_delta_v > delta_v)
            delta_v <= spike_delta_v;
         if (wr && paddr == `OFF_QMAX)
            qmax <= pwdata[15:0];
         else if (qmax_learn && qmax_update)
            qmax <= qmax_new;
         // host writes to the status code are not taken
         if (algorithm_enable_cmd)
            learning_status <= `LS_EN_NONE;
         else if (learning_status != `LS_LEARNED_OFF) begin
            if (res_learn && learning_status == `LS_EN_QMAX)
               learning_status <= `LS_EN_ALL;
            else if (qmax_learn && qmax_update &&
                     learning_status == `LS_EN_NONE)
               learning_status <= `LS_EN_QMAX;
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (res_learn && 32'(res_index) < RES_ENTRIES)
         res_tbl[res_index] <= res_value;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // exit is only judged while relaxed: in flow the entry rules win
   sequence quit_held;
      sec_tick && state != ST_FLOW && mag_avg > mag_quit &&
      t_quit + 16'h0001 >= quit_relax_time;
   endsequence

   sequence dsg_held;
      sec_tick && state == ST_FLOW && mag_avg < mag_quit &&
      t_dsg + 16'h0001 >= dsg_relax_time;
   endsequence

   sequence chg_held;
      sec_tick && state == ST_FLOW && mag_avg > mag_quit &&
      t_chg + 16'h0001 >= chg_relax_time;
   endsequence

   relax_exit_a: assert property (quit_held ##1 1 |=> !relax_mode)
      else $error("relax not left after quit time");
   ocv_gate_a: assert property (
      $rose(ocv_take) |-> $past(relax_mode))
      else $error("ocv reading outside relax");
   slope_gate_a: assert property (
      qmax_update |-> $past(voltage_slope_uv) < 16'(`SLOPE_LIMIT_UV))
      else $error("capacity update with steep slope");
   timer_clear_a: assert property (
      sec_tick && !(mag_avg < mag_quit) |=> t_dsg == 16'h0000)
      else $error("discharge relax timer not cleared");
   dsg_class_a: assert property (
      dsg_flow |-> $past(mag_inst) > $past(dsg_thr))
      else $error("discharge flagged under threshold");
   chg_class_a: assert property (
      chg_flow |-> $past(mag_inst) > $past(chg_thr))
      else $error("charge flagged under threshold");
   scale_legal_a: assert property (
      energy_scale == `SCALE_UNIT || energy_scale == `SCALE_CENTI)
      else $error("illegal energy scale");
   status_code_a: assert property (
      learning_status inside {`LS_LEARNED_OFF, `LS_EN_NONE,
                              `LS_EN_QMAX, `LS_EN_ALL})
      else $error("bad learning status");
   relax_enter_a: assert property (dsg_held |=> ##1 relax_mode)
      else $error("relax not entered");
   chg_enter_a: assert property (chg_held |=> ##1 relax_mode)
      else $error("relax not entered on charge");
   status_hold_a: assert property (
      !algorithm_enable_cmd && !qmax_learn && !res_learn
      |=> $stable(learning_status))
      else $error("learning status changed outside learning");
   qmax_keep_a: assert property (
      qmax_learn && !qmax_update && !(wr && paddr == `OFF_QMAX)
      |=> $stable(qmax))
      else $error("capacity learned outside relax");
   scale_keep_a: assert property (
      wr && paddr == `OFF_ENERGY_SCALE &&
      !(pwdata[7:0] inside {`SCALE_UNIT, `SCALE_CENTI})
      |=> $stable(energy_scale))
      else $error("illegal energy scale taken");
   avg_hold_a: assert property (
      sec_tick && dsg_now |=> $stable(avg_i_last))
      else $error("last-run current changed mid discharge");
   reserve_flag_a: assert property (
      remaining_charge == 16'h0000 |=> reserve_active)
      else $error("reserve not flagged at empty");
endmodule

// *** test/gauge_host.sv ***
// apb host model driving the gauge control registers
// assumes the bench supplies pclk and calls xfer from its sequence
`timescale 1ns/1ns
module gauge_host (
   // clock
   input  wire logic        pclk,
   // apb master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   int stalls = 0;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   // scale writes stay at 1 or 10 except where a refusal is meant
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // answer is taken at the rising edge that samples pready high
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) stalls++;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released data must not keep showing the old word
      pwdata  <= ~d;
   endtask
endmodule

// *** test/gauge_relax_and_learning_control_test.sv ***
// self-checking bench for the relax and learning control block
// assumes gauge_host as apb master and the bench as sample source
`timescale 1ns/1ns
`include "gauge_consts.svh"
module gauge_relax_and_learning_control_test;
   localparam int OCV = 4;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        e, sec_tick, qmax_learn, res_learn;
   logic        relax_mode, ocv_take, qmax_update, dsg_flow, chg_flow, rsv;
   logic signed [15:0] avg_i;
   logic [15:0] volt, slope, spike, rem, avail, qnew, rval, nlr, ldr;
   logic [15:0] sp[3];
   logic [3:0]  ridx;
   int          num_errors = 0;
   int          checks = 0;
   int          c;
   int          corners[4] = '{-60, -61, 75, 76};
   int          scales[2] = '{10, 1};

   gauge_host host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata));
   gauge_relax_ctrl #(.OCV_WAIT_CYC(OCV)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .sec_tick(sec_tick), .averaged_current(avg_i),
      .inst_current(avg_i), .cell_voltage(volt), .voltage_slope_uv(slope),
      .spike_delta_v(spike), .remaining_charge(rem),
      .available_energy_report(avail), .no_load_reserve(nlr),
      .loaded_reserve(ldr), .qmax_learn(qmax_learn),
      .qmax_new(qnew), .res_learn(res_learn), .res_index(ridx),
      .res_value(rval), .relax_mode(relax_mode), .ocv_take(ocv_take),
      .qmax_update(qmax_update), .dsg_flow(dsg_flow),
      .chg_flow(chg_flow), .reserve_active(rsv));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] avg_p(input int i, v, s);
      return (i * v) / ((s == 10) ? 10000 : 1000);
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, q, e);
      cmp(q, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge pclk);
         sec_tick <= 1'b1;
         @(posedge pclk);
         sec_tick <= 1'b0;
         repeat (2) @(posedge pclk);
      end
      @(negedge pclk);
   endtask
   task automatic cur(input logic signed [15:0] v);
      @(posedge pclk);
      avg_i <= v;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask
   // capacity is only learned while relaxed with a flat voltage
   task automatic learn(input bit upd);
      @(posedge pclk);
      qnew <= 16'($urandom_range(2000, 1));
      qmax_learn <= 1'b1;
      @(posedge pclk);
      qmax_learn <= 1'b0;
      rd(`OFF_QMAX, upd ? {16'h0, qnew} : 32'd1000);
      rd(`OFF_LEARN_STAT, upd ? `LS_EN_QMAX : `LS_EN_NONE);
      @(posedge pclk);
      ridx <= 4'h3;
      rval <= 16'($urandom);
      res_learn <= 1'b1;
      @(posedge pclk);
      res_learn <= 1'b0;
      rd(`OFF_RES_TBL + 12'h00c, {16'h0, rval});
      rd(`OFF_LEARN_STAT, upd ? `LS_EN_ALL : `LS_EN_NONE);
   endtask
   task automatic final_report();
      $display("checks=%0d num_errors=%0d", checks, num_errors + host.stalls);
      if (num_errors + host.stalls == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ------------------------------------------------------------
   // clock, watchdog, sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      final_report();
   end
   initial begin
      {presetn, sec_tick, qmax_learn, res_learn} = 4'h0;
      {avg_i, slope, spike, qnew, rval, ridx} = '0;
      volt = 16'd3600;
      rem = 16'd500;
      avail = 16'd500;
      void'($urandom(32'hde0f));
      nlr = 16'($urandom);
      ldr = ~nlr;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFF_PACK_CFG, `PACK_CFG_RESET);
      rd(`OFF_CTRL, {16'h0, ldr});
      rd(`OFF_LEARN_STAT, `LS_LEARNED_OFF);
      rd(`OFF_QUIT_CUR, 32'd10);
      rd(`OFF_QMAX, 32'd1000);
      wr(`OFF_PACK_CFG, 32'h8161);
      rd(`OFF_PACK_CFG, 32'h8161);
      rd(`OFF_CTRL, {16'h0, nlr});
      host.xfer(1'b0, 12'h0fc, 32'h0, q, e);
      cmp({q[30:0], e}, 32'h1);
      $display("test registers done");
      wr(`OFF_LEARN_STAT, 32'h06);
      rd(`OFF_LEARN_STAT, `LS_LEARNED_OFF);
      wr(`OFF_CTRL, 32'h1);
      rd(`OFF_LEARN_STAT, `LS_EN_NONE);
      learn(1'b0);
      $display("test learning done");
      rd(`OFF_ENERGY_SCALE, `SCALE_UNIT);
      wr(`OFF_ENERGY_SCALE, `SCALE_CENTI);
      wr(`OFF_ENERGY_SCALE, 32'h5);
      rd(`OFF_ENERGY_SCALE, `SCALE_CENTI);
      foreach (scales[k]) begin
         wr(`OFF_ENERGY_SCALE, scales[k]);
         cur(-16'sd100);
         tick(4);
         cur(16'sd0);
         tick(1);
         rd(`OFF_AVG_P_LAST, avg_p(100, 3600, scales[k]));
         host.xfer(1'b0, `OFF_AVG_I_LAST, 32'h0, q, e);
         cmp({16'h0, q[15] ? -q[15:0] : q[15:0]}, 32'd100);
      end
      sp = '{16'($urandom_range(150, 1)), 16'd200, 16'($urandom_range(150, 1))};
      foreach (sp[k]) begin
         @(posedge pclk);
         spike <= sp[k];
         tick(1);
      end
      rd(`OFF_DELTA_V, 32'd200);
      for (int k = 0; k < 12; k++) begin
         c = (k < 4) ? corners[k] : int'($urandom_range(400)) - 200;
         cur(16'(c));
         cmp({31'h0, dsg_flow}, {31'h0, c < -60});
         cmp({31'h0, chg_flow}, {31'h0, c > 75});
      end
      $display("test averages and flow done");
      @(posedge pclk);
      rem <= 16'h0;
      repeat (3) @(posedge pclk);
      cmp({31'h0, rsv}, 32'h1);
      @(posedge pclk);
      rem <= 16'd500;
      avail <= 16'h0;
      repeat (3) @(posedge pclk);
      cmp({31'h0, rsv}, 32'h1);
      @(posedge pclk);
      avail <= 16'd500;
      repeat (3) @(posedge pclk);
      cmp({31'h0, rsv}, 32'h0);
      // a fresh reset clears whatever the relax timers counted so far
      @(posedge pclk);
      presetn <= 1'b0;
      avg_i <= 16'sd5;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wr(`OFF_RELAX_TIMES, 32'h0005_0003);
      wr(`OFF_QUIT_TIME, 32'd2);
      tick(2); // current kept under the quit current of 10
      cmp({31'h0, relax_mode}, 32'h0);
      cur(16'sd20);
      tick(1);
      cur(16'sd5);
      tick(2);
      cmp({31'h0, relax_mode}, 32'h0);
      tick(1);
      cmp({30'h0, relax_mode, ocv_take}, 32'h2);
      @(posedge pclk);
      slope <= 16'd3;
      tick(OCV + 1);
      cmp({30'h0, ocv_take, qmax_update}, 32'h3);
      wr(`OFF_CTRL, 32'h1);
      learn(1'b1);
      @(posedge pclk);
      slope <= 16'd4;
      repeat (3) @(negedge pclk);
      cmp({31'h0, qmax_update}, 32'h0);
      cur(16'sd20);
      tick(1);
      cmp({31'h0, relax_mode}, 32'h1);
      tick(1);
      cmp({31'h0, relax_mode}, 32'h0);
      tick(3);
      cmp({31'h0, relax_mode}, 32'h1);
      $display("test relax done");
      final_report();
   end
endmodule
